// File: hdl/aicd_decoder.v
// Immediate command decoder and executor for one axis of a motion controller.
// Assumes the host writes three command words and then strobes the scan offset
// once per scan; axis status inputs are synchronous to core_clk.
`include "aicd_map.vh"

// What this block does
// R1: Code 34h forces servo velocity, +-4095 RPM; analog velocity mode clears the force instead.
// R2: Codes 40h/41h select return data slots.
// R3: Code 42h sets make-up time, 0 or 10-32000.
// R4: Code 46h sub 07/08 sets speed gains, torque mode only.
// R5: Code 47h routes analog output, digital only.
// R6: Code 49h clears new-configuration indication.
// R7: Code 50h loads numbered parameter data.
// R8: Host writes only 00 or FFh sign bytes.
// R9: Host keeps null command when idle.
// R10: Rate override persists, affects programmed velocity only.
// R11: Rate override returns to 100% on start; a valid rate command scanned in the same cycle wins.
// R12: Increment without update keeps positions unchanged.
// R13: Velocity move uses jog acceleration, wraps position.
// R14: Servo set position adds position error.
// R15: Set position refused moving, active, or fast.
// R16: Limit error; success sets position valid.
// R17: Auxiliary set position changes commanded only.
// R18: Unreferenced absolute encoder: ignore, error 53h.
// R19: Forced analog output spans +-32000.
// R20: Forced analog unavailable in torque mode.
// R21: Force holds while present and drive enabled.
// R22: Any other command cancels forced analog.
module aicd_decoder (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst_n,
  // Register port
  input  wire [3:0]  bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  // Axis configuration and status
  input  wire [1:0]  axis_mode,
  input  wire        aux_axis,
  input  wire        servo_on,
  input  wire        drive_enable,
  input  wire        moving,
  input  wire        prog_active,
  input  wire        in_zone,
  input  wire        prog_start,
  input  wire        enc_unref,
  input  wire [31:0] act_vel_abs,
  input  wire [31:0] pos_err,
  input  wire [31:0] travel_hi,
  input  wire [31:0] travel_lo,
  input  wire [31:0] count_hi,
  input  wire [31:0] count_lo,
  input  wire [15:0] pos_delta,
  // Loop settings
  output reg  [7:0]  rate_override_ff,
  output reg  [15:0] servo_vel_ff,
  output reg         servo_vel_force_ff,
  output reg  [7:0]  ret1_mode_ff,
  output reg  [15:0] ret1_offset_ff,
  output reg  [7:0]  ret2_mode_ff,
  output reg  [15:0] ret2_offset_ff,
  output reg  [15:0] makeup_time_ff,
  output reg  [14:0] speed_loop_prop_gain,
  output reg  [14:0] speed_loop_integral_gain,
  output reg  [7:0]  aout_axis_ff,
  output reg  [7:0]  aout_mode_ff,
  // One-cycle actions
  output reg         cfg_new_clear_ff,
  output reg         param_load_ff,
  output reg  [7:0]  param_num_ff,
  output reg  [31:0] param_data_ff,
  output reg         incr_pulse_ff,
  output reg  [7:0]  incr_value_ff,
  // Motion and positions
  output reg         vel_move_ff,
  output reg  [31:0] vel_move_speed_ff,
  output reg  [31:0] actual_pos_ff,
  output reg  [31:0] cmd_pos_ff,
  output reg         pos_valid_ff,
  // Errors and analog output
  output reg         error_ff,
  output reg  [7:0]  error_code_ff,
  output reg  [15:0] analog_out_ff,
  output reg         analog_on_ff
);

  // ==========================================================
  // Command words
  reg  [15:0] word0_ff;
  reg  [15:0] word1_ff;
  reg  [15:0] word2_ff;
  reg         force_ff;
  reg  [15:0] force_val_ff;

  wire        scan     = bus_wr && (bus_addr == `AICD_OFS_SCAN);
  wire [7:0]  code     = word0_ff[7:0];
  wire [7:0]  sub      = word0_ff[15:8];
  wire [15:0] d23      = word1_ff;
  wire [31:0] d25      = {word2_ff, word1_ff};
  wire        sign_ok  = (word1_ff[15:8] == 8'h00) || (word1_ff[15:8] == 8'hFF);
  wire        torque   = (axis_mode == `AICD_MODE_ANATRQ);

  // ==========================================================
  // Range checks
  wire signed [15:0] s23 = d23;
  wire        srvvel_ok = (s23 <= $signed(`AICD_SRVVEL_MAX)) && (s23 >= -$signed(`AICD_SRVVEL_MAX));
  wire        makeup_ok = (d23 == 16'h0000) || ((d23 >= `AICD_MAKEUP_MIN) && (d23 <= `AICD_MAKEUP_MAX));
  wire        aout_ok   = (s23 <= $signed(`AICD_AOUT_MAX)) && (s23 >= -$signed(`AICD_AOUT_MAX));
  wire        in_travel = ($signed(d25) <= $signed(travel_hi)) && ($signed(d25) >= $signed(travel_lo));
  wire        in_count  = ($signed(d25) <= $signed(count_hi)) && ($signed(d25) >= $signed(count_lo));
  wire        sp_busy   = moving || prog_active || (!in_zone && (act_vel_abs > `AICD_SETPOS_VMAX));

  // ==========================================================
  // Position tracking with roll-over during velocity moves
  wire [31:0] span      = travel_hi - travel_lo + 32'h00000001;
  wire [31:0] sum_pos   = actual_pos_ff + {{16{pos_delta[15]}}, pos_delta};
  reg  [31:0] nxt_actual;

  always @* begin
    nxt_actual = sum_pos;
    if (vel_move_ff && !aux_axis) begin
      if ($signed(sum_pos) > $signed(travel_hi))
        nxt_actual = sum_pos - span; // [R13]
      else if ($signed(sum_pos) < $signed(travel_lo))
        nxt_actual = sum_pos + span; // [R13]
    end
    // Auxiliary axis: actual position belongs to its own encoder
    if (aux_axis)
      nxt_actual = actual_pos_ff;
  end

  // ==========================================================
  // Decode and execute
  always @(posedge core_clk) begin
    if (!rst_n) begin
      word0_ff                 <= 16'h0000;
      word1_ff                 <= 16'h0000;
      word2_ff                 <= 16'h0000;
      bus_rdata                <= 16'h0000;
      rate_override_ff         <= `AICD_RATE_RESET;
      servo_vel_ff             <= 16'h0000;
      servo_vel_force_ff       <= 1'b0;
      ret1_mode_ff             <= 8'h00;
      ret1_offset_ff           <= 16'h0000;
      ret2_mode_ff             <= 8'h00;
      ret2_offset_ff           <= 16'h0000;
      makeup_time_ff           <= 16'h0000;
      speed_loop_prop_gain     <= 15'h0000;
      speed_loop_integral_gain <= 15'h0000;
      aout_axis_ff             <= 8'h00;
      aout_mode_ff             <= 8'h00;
      cfg_new_clear_ff         <= 1'b0;
      param_load_ff            <= 1'b0;
      param_num_ff             <= 8'h00;
      param_data_ff            <= 32'h00000000;
      incr_pulse_ff            <= 1'b0;
      incr_value_ff            <= 8'h00;
      vel_move_ff              <= 1'b0;
      vel_move_speed_ff        <= 32'h00000000;
      actual_pos_ff            <= 32'h00000000;
      cmd_pos_ff               <= 32'h00000000;
      pos_valid_ff             <= 1'b0;
      error_ff                 <= 1'b0;
      error_code_ff            <= `AICD_ERR_NONE;
      force_ff                 <= 1'b0;
      force_val_ff             <= 16'h0000;
      analog_out_ff            <= 16'h0000;
      analog_on_ff             <= 1'b0;
    end else begin
      cfg_new_clear_ff <= 1'b0;
      param_load_ff    <= 1'b0;
      incr_pulse_ff    <= 1'b0;
      actual_pos_ff    <= nxt_actual;

      // Register port
      if (bus_wr) begin
        case (bus_addr)
          `AICD_OFS_WORD0: word0_ff <= bus_wdata;
          `AICD_OFS_WORD1: word1_ff <= bus_wdata;
          `AICD_OFS_WORD2: word2_ff <= bus_wdata;
          // A scan write never shares a cycle with an error clear
          `AICD_OFS_ERROR: begin
            error_ff      <= 1'b0;
            error_code_ff <= `AICD_ERR_NONE;
          end
          default: ;
        endcase
      end
      if (bus_rd) begin
        case (bus_addr)
          `AICD_OFS_WORD0:  bus_rdata <= word0_ff;
          `AICD_OFS_WORD1:  bus_rdata <= word1_ff;
          `AICD_OFS_WORD2:  bus_rdata <= word2_ff;
          `AICD_OFS_STATUS: bus_rdata <= {11'h000, servo_vel_force_ff, analog_on_ff,
                                          vel_move_ff, pos_valid_ff, error_ff};
          `AICD_OFS_ERROR:  bus_rdata <= {8'h00, error_code_ff};
          `AICD_OFS_RATE:   bus_rdata <= {8'h00, rate_override_ff};
          `AICD_OFS_ANALOG: bus_rdata <= analog_out_ff;
          default:          bus_rdata <= 16'h0000;
        endcase
      end else begin
        // Read data stand for one cycle only
        bus_rdata <= 16'h0000;
      end

      if (prog_start)
        rate_override_ff <= `AICD_RATE_RESET; // [R11]

      // Latched words execute once per scan strobe; a held code repeats each scan
      if (scan) begin
        if (code != `AICD_CMD_FORCEAO)
          force_ff <= 1'b0; // [R22]
        if (code != `AICD_CMD_NULL && code != `AICD_CMD_MOVEVEL)
          vel_move_ff <= 1'b0;
        case (code)
          `AICD_CMD_NULL: ;
          `AICD_CMD_RATE: begin
            if (d23[7:0] <= `AICD_RATE_MAX)
              rate_override_ff <= d23[7:0]; // [R10]
            else begin
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_RANGE;
            end
          end
          `AICD_CMD_INCR, `AICD_CMD_INCRUPD: begin
            if (sign_ok) begin // [R8]
              incr_pulse_ff <= servo_on;
              incr_value_ff <= d23[7:0]; // [R12]
              if (code == `AICD_CMD_INCRUPD) begin
                actual_pos_ff <= nxt_actual + {{24{d23[7]}}, d23[7:0]};
                cmd_pos_ff    <= cmd_pos_ff + {{24{d23[7]}}, d23[7:0]};
              end
            end else begin
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_RANGE;
            end
          end
          `AICD_CMD_MOVEVEL: begin
            vel_move_ff       <= 1'b1; // [R13]
            vel_move_speed_ff <= d25;
          end
          `AICD_CMD_SETPOS: begin
            if (enc_unref && !aux_axis) begin
              error_ff      <= 1'b1; // [R18]
              error_code_ff <= `AICD_ERR_ENCREF;
            end else if (moving || prog_active || (!aux_axis && sp_busy)) begin
              error_ff      <= 1'b1; // [R15]
              error_code_ff <= `AICD_ERR_BUSY;
            end else if (!in_travel || (!aux_axis && !in_count)) begin
              error_ff      <= 1'b1; // [R16]
              error_code_ff <= `AICD_ERR_LIMIT;
            end else begin
              pos_valid_ff <= 1'b1; // [R16]
              if (aux_axis)
                cmd_pos_ff <= d25; // [R17]
              else begin
                actual_pos_ff <= d25; // [R14]
                cmd_pos_ff    <= d25 + pos_err; // [R14]
              end
            end
          end
          `AICD_CMD_FORCEAO: begin
            if (torque) begin
              error_ff      <= 1'b1; // [R20]
              error_code_ff <= `AICD_ERR_MODE;
            end else if (aout_ok) begin
              force_ff     <= 1'b1; // [R21]
              force_val_ff <= d23; // [R19]
            end else begin
              force_ff      <= 1'b0;
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_RANGE;
            end
          end
          `AICD_CMD_SRVVEL: begin
            if (axis_mode == `AICD_MODE_ANAVEL)
              servo_vel_force_ff <= 1'b0; // [R1]
            else if (srvvel_ok) begin
              servo_vel_force_ff <= 1'b1; // [R1]
              servo_vel_ff       <= d23;
            end else begin
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_RANGE;
            end
          end
          `AICD_CMD_RET1: begin
            ret1_mode_ff   <= sub; // [R2]
            ret1_offset_ff <= d23;
          end
          `AICD_CMD_RET2: begin
            ret2_mode_ff   <= sub; // [R2]
            ret2_offset_ff <= d23;
          end
          `AICD_CMD_MAKEUP: begin
            if (makeup_ok)
              makeup_time_ff <= d23; // [R3]
            else begin
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_RANGE;
            end
          end
          `AICD_CMD_VELREG: begin
            if (!torque || d23[15] || (sub != `AICD_SUB_KP && sub != `AICD_SUB_KI)) begin
              error_ff      <= 1'b1; // [R4]
              error_code_ff <= torque ? `AICD_ERR_RANGE : `AICD_ERR_MODE;
            end else if (sub == `AICD_SUB_KP)
              speed_loop_prop_gain <= d23[14:0]; // [R4]
            else
              speed_loop_integral_gain <= d23[14:0]; // [R4]
          end
          `AICD_CMD_AOSEL: begin
            if (axis_mode == `AICD_MODE_DIGITAL) begin
              aout_axis_ff <= sub; // [R5]
              aout_mode_ff <= d23[7:0];
            end else begin
              error_ff      <= 1'b1;
              error_code_ff <= `AICD_ERR_MODE;
            end
          end
          `AICD_CMD_CFGCLR: cfg_new_clear_ff <= 1'b1; // [R6]
          `AICD_CMD_PARAM: begin
            param_load_ff <= 1'b1; // [R7]
            param_num_ff  <= sub;
            param_data_ff <= d25;
          end
          default: ;
        endcase
      end

      // Forced output drives only with drive enable on
      if (force_ff && drive_enable && !torque) begin
        analog_out_ff <= force_val_ff; // [R21]
        analog_on_ff  <= 1'b1;
      end else begin
        analog_out_ff <= 16'h0000; // [R22]
        analog_on_ff  <= 1'b0;
      end
    end
  end

endmodule // aicd_decoder

// File: hdl/aicd_map.vh
// Constants of the per-axis immediate command decoder: bus offsets, command codes,
// error codes and range limits. Assumes word 0 byte 0 is the code, byte 1 the sub-code.
`ifndef AICD_MAP_VH
`define AICD_MAP_VH
// ==========================================================
// Register offsets (word index on the plain port)
`define AICD_OFS_WORD0    4'h0
`define AICD_OFS_WORD1    4'h1
`define AICD_OFS_WORD2    4'h2
`define AICD_OFS_SCAN     4'h3
`define AICD_OFS_STATUS   4'h4
`define AICD_OFS_ERROR    4'h5
`define AICD_OFS_RATE     4'h6
`define AICD_OFS_ANALOG   4'h7
// ==========================================================
// Command codes
`define AICD_CMD_NULL     8'h00
`define AICD_CMD_RATE     8'h20
`define AICD_CMD_INCR     8'h21
`define AICD_CMD_MOVEVEL  8'h22
`define AICD_CMD_SETPOS   8'h23
`define AICD_CMD_FORCEAO  8'h24
`define AICD_CMD_INCRUPD  8'h25
`define AICD_CMD_SRVVEL   8'h34
`define AICD_CMD_RET1     8'h40
`define AICD_CMD_RET2     8'h41
`define AICD_CMD_MAKEUP   8'h42
`define AICD_CMD_VELREG   8'h46
`define AICD_CMD_AOSEL    8'h47
`define AICD_CMD_CFGCLR   8'h49
`define AICD_CMD_PARAM    8'h50
`define AICD_SUB_KP       8'h07
`define AICD_SUB_KI       8'h08
// ==========================================================
// Axis modes
`define AICD_MODE_DIGITAL 2'h0
`define AICD_MODE_ANAVEL  2'h1
`define AICD_MODE_ANATRQ  2'h2
// ==========================================================
// Error codes
`define AICD_ERR_NONE     8'h00
`define AICD_ERR_ENCREF   8'h53
`define AICD_ERR_RANGE    8'h60
`define AICD_ERR_BUSY     8'h61
`define AICD_ERR_MODE     8'h62
`define AICD_ERR_LIMIT    8'h63
// ==========================================================
// Limits and reset values
`define AICD_SRVVEL_MAX   16'h0FFF
`define AICD_MAKEUP_MIN   16'h000A
`define AICD_MAKEUP_MAX   16'h7D00
`define AICD_AOUT_MAX     16'h7D00
`define AICD_SETPOS_VMAX  32'h00000064
`define AICD_RATE_RESET   8'h64
`define AICD_RATE_MAX     8'h78
`endif

// File: tb/aicd_decoder_sva.sv
// Concurrent checks on the immediate command decoder ports.
// Assumes one clock domain; attached to every decoder instance by bind.
module aicd_decoder_sva (
  // Clock, reset and bus
  input logic        core_clk,
  input logic        rst_n,
  input logic [3:0]  bus_addr,
  input logic [15:0] bus_wdata,
  input logic        bus_wr,
  // Axis status
  input logic [1:0]  axis_mode,
  input logic        aux_axis,
  input logic        drive_enable,
  input logic        moving,
  input logic        prog_active,
  input logic        in_zone,
  input logic        prog_start,
  input logic        enc_unref,
  input logic [31:0] act_vel_abs,
  input logic [31:0] pos_err,
  input logic [31:0] travel_hi,
  input logic [31:0] travel_lo,
  input logic [31:0] count_hi,
  input logic [31:0] count_lo,
  // Results
  input logic [7:0]  rate_override_ff,
  input logic        cfg_new_clear_ff,
  input logic [31:0] cmd_pos_ff,
  input logic        pos_valid_ff,
  input logic        error_ff,
  input logic [7:0]  error_code_ff,
  input logic [15:0] analog_out_ff,
  input logic        analog_on_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Shadow of the command words
  logic [7:0]  code_ff;
  logic [31:0] pos_ff;
  wire scan_w = bus_wr && bus_addr == 4'h3;
  wire ok_w = !aux_axis && !moving && !prog_active && !enc_unref && (in_zone || act_vel_abs <= 32'h00000064)
    && $signed(pos_ff) <= $signed(travel_hi) && $signed(pos_ff) >= $signed(travel_lo)
    && $signed(pos_ff) <= $signed(count_hi) && $signed(pos_ff) >= $signed(count_lo);
  always @(posedge core_clk) begin
    if (!rst_n) begin
      code_ff <= 8'h00;
      pos_ff  <= 32'h00000000;
    end else if (bus_wr && bus_addr == 4'h0) begin
      code_ff <= bus_wdata[7:0];
    end else if (bus_wr && bus_addr == 4'h1) begin
      pos_ff[15:0] <= bus_wdata;
    end else if (bus_wr && bus_addr == 4'h2) begin
      pos_ff[31:16] <= bus_wdata;
    end
  end
  // ==========================================================
  // Properties
  sequence s_scan(logic [7:0] c);
    scan_w && code_ff == c;
  endsequence
  sequence s_pulse;
    cfg_new_clear_ff ##1 !cfg_new_clear_ff;
  endsequence
  chk_rate_restart: assert property (prog_start && !scan_w |=> rate_override_ff == 8'h64)
    else $error("rate override not restored on start");
  chk_cfg_pulse: assert property (s_scan(8'h49) |=> s_pulse)
    else $error("config clear pulse missing");
  chk_force_cancel: assert property (scan_w && code_ff != 8'h24 |-> ##2 !analog_on_ff)
    else $error("analog force not cancelled");
  chk_ao_enable: assert property (!drive_enable |=> !analog_on_ff)
    else $error("analog on without drive enable");
  chk_ao_torque: assert property (axis_mode == 2'h2 |=> !analog_on_ff)
    else $error("analog forced in torque mode");
  chk_ao_range: assert property (analog_on_ff |-> $signed(analog_out_ff) <= $signed(16'h7D00)
    && $signed(analog_out_ff) >= $signed(16'h8300))
    else $error("analog output out of span");
  chk_setpos_busy: assert property (s_scan(8'h23) ##0 (moving || prog_active) && !enc_unref
    |=> error_ff && error_code_ff == 8'h61 && $stable(cmd_pos_ff))
    else $error("set position not refused while busy");
  chk_setpos_load: assert property (s_scan(8'h23) ##0 ok_w
    |=> cmd_pos_ff == $past(pos_ff) + $past(pos_err) && pos_valid_ff)
    else $error("set position load wrong");
  chk_enc_unref: assert property (s_scan(8'h23) ##0 enc_unref |=> error_code_ff == 8'h53 && $stable(cmd_pos_ff))
    else $error("unreferenced encoder not reported");
  chk_incr_keep: assert property (s_scan(8'h21) |=> $stable(cmd_pos_ff))
    else $error("increment changed commanded position");
endmodule // aicd_decoder_sva

bind aicd_decoder aicd_decoder_sva i_chk (.*);

// File: tb/aicd_host_model.sv
// Host model: writes three command words and the scan strobe each scan.
// Assumes tasks are called from the bench once reset has been released.
module aicd_host_model (
  // Clock
  input  logic        core_clk,
  // Register port
  output logic [3:0]  bus_addr,
  output logic [15:0] bus_wdata,
  output logic        bus_wr,
  output logic        bus_rd,
  input  logic [15:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    bus_addr  = 4'h0;
    bus_wdata = 16'h0000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
  end
  // ==========================================================
  // Bus cycles
  task automatic scan(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    logic [15:0] w [4];
    w = '{w0, w1, w2, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= 4'(i);
      bus_wdata <= w[i];
    end
    @(posedge core_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~w[3];
    #1;
  endtask
  task automatic null_scan;
    scan(16'h0000, 16'h0000, 16'h0000);
  endtask
  task automatic incr(input logic [7:0] v);
    scan(16'h0021, {{8{v[7]}}, v}, 16'h0000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge core_clk);
    bus_wr    <= 1'b0;
    bus_wdata <= ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge core_clk);
    bus_rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
endmodule // aicd_host_model

// File: tb/axis_immediate_command_decoder_tb_top.sv
// Self-checking bench for the immediate command decoder.
// Assumes the host model drives the register port and the bench the axis status.
module axis_immediate_command_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 0, rst_n = 0, aux_axis = 0, servo_on = 0, drive_enable = 0, moving = 0;
  logic        prog_active = 0, in_zone = 1, prog_start = 0, enc_unref = 0;
  logic [1:0]  axis_mode = 2'h0;
  logic [31:0] act_vel_abs = 0, pos_err = 0, travel_hi = 32'h00010000, travel_lo = 32'hFFFF0000;
  logic [31:0] count_hi = 32'h7FFFFFFF, count_lo = 32'h80000000;
  logic [15:0] pos_delta = 16'h0000, rd_val;
  wire  [3:0]  bus_addr;
  wire  [15:0] bus_wdata, bus_rdata, servo_vel_ff, ret1_offset_ff, ret2_offset_ff, makeup_time_ff, analog_out_ff;
  wire         bus_wr, bus_rd, servo_vel_force_ff, cfg_new_clear_ff, param_load_ff, incr_pulse_ff, vel_move_ff;
  wire         pos_valid_ff, error_ff, analog_on_ff;
  wire  [7:0]  rate_override_ff, ret1_mode_ff, ret2_mode_ff, aout_axis_ff, aout_mode_ff, param_num_ff;
  wire  [7:0]  incr_value_ff, error_code_ff;
  wire  [14:0] speed_loop_prop_gain, speed_loop_integral_gain;
  wire  [31:0] param_data_ff, vel_move_speed_ff, actual_pos_ff, cmd_pos_ff;
  int          err_count = 0, n_tests = 0;
  aicd_decoder    i_dut (.*);
  aicd_host_model i_host (.*);
  initial forever #4 core_clk = ~core_clk;
  // ==========================================================
  // Ordinary cases: mode, word0, word1, word2, output select, expected
  localparam logic [85:0] ROWS [11] = '{
    {2'h0, 16'h0020, 16'h0032, 16'h0000, 4'h0, 32'h00000032},
    {2'h0, 16'h0034, 16'h0FFF, 16'h0000, 4'h1, 32'h00000FFF},
    {2'h0, 16'h0340, 16'h1234, 16'h0000, 4'h2, 32'h00031234},
    {2'h0, 16'h0541, 16'h5678, 16'h0000, 4'h3, 32'h00055678},
    {2'h0, 16'h0042, 16'h7D00, 16'h0000, 4'h4, 32'h00007D00},
    {2'h0, 16'h0042, 16'h000A, 16'h0000, 4'h4, 32'h0000000A},
    {2'h0, 16'h0042, 16'h0009, 16'h0000, 4'h4, 32'h0000000A},
    {2'h2, 16'h0746, 16'h7FFF, 16'h0000, 4'h5, 32'h00007FFF},
    {2'h2, 16'h0846, 16'h1234, 16'h0000, 4'h6, 32'h00001234},
    {2'h0, 16'h0247, 16'h0005, 16'h0000, 4'h7, 32'h00000205},
    {2'h0, 16'hFF50, 16'h5A5A, 16'hA5A5, 4'h8, 32'hA5A55A5A}};
  function automatic logic [31:0] sel_out(input logic [3:0] s);
    case (s)
      4'h0: return {24'h0, rate_override_ff};
      4'h1: return {16'h0, servo_vel_ff};
      4'h2: return {8'h0, ret1_mode_ff, ret1_offset_ff};
      4'h3: return {8'h0, ret2_mode_ff, ret2_offset_ff};
      4'h4: return {16'h0, makeup_time_ff};
      4'h5: return {17'h0, speed_loop_prop_gain};
      4'h6: return {17'h0, speed_loop_integral_gain};
      4'h7: return {16'h0, aout_axis_ff, aout_mode_ff};
      default: return param_data_ff;
    endcase
  endfunction
  // ==========================================================
  // Checking and closing
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic sp(input logic [31:0] v, input logic [7:0] e);
    i_host.wr(4'h5, 16'h0000);
    i_host.scan(16'h0023, v[15:0], v[31:16]);
    chk(error_ff, e != 8'h00);
    if (e != 8'h00) chk(error_code_ff, e);
  endtask
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    chk(rate_override_ff, 8'h64);
    chk(analog_on_ff, 1'b0);
    for (int r = 0; r < 11; r++) begin
      axis_mode <= ROWS[r][85:84];
      i_host.scan(ROWS[r][83:68], ROWS[r][67:52], ROWS[r][51:36]);
      chk(sel_out(ROWS[r][35:32]), ROWS[r][31:0]);
    end
    chk(param_num_ff, 8'hFF);
    chk(param_load_ff, 1'b1);
    chk(servo_vel_force_ff, 1'b1);
    axis_mode <= 2'h1;
    i_host.wr(4'h5, 16'h0000);
    i_host.scan(16'h0034, 16'h0100, 16'h0000);
    chk({servo_vel_force_ff, error_ff}, 2'b00);
    i_host.scan(16'h0347, 16'h0009, 16'h0000);
    chk({error_code_ff, aout_axis_ff, aout_mode_ff}, 24'h620205);
    i_host.scan(16'h0021, 16'h1280, 16'h0000);
    chk({incr_pulse_ff, error_code_ff}, 9'h060);
    prog_start <= 1'b1;
    tick();
    prog_start <= 1'b0;
    chk(rate_override_ff, 8'h64);
    i_host.scan(16'h0020, 16'h0078, 16'h0000);
    i_host.scan(16'h0020, 16'h0079, 16'h0000);
    chk(rate_override_ff, 8'h78);
    axis_mode <= 2'h0;
    drive_enable <= 1'b1;
    i_host.scan(16'h0024, 16'h3E80, 16'h0000);
    tick();
    chk({analog_on_ff, analog_out_ff}, 17'h13E80);
    drive_enable <= 1'b0;
    tick();
    chk(analog_on_ff, 1'b0);
    drive_enable <= 1'b1;
    i_host.scan(16'h0024, 16'h8300, 16'h0000);
    tick();
    chk({analog_on_ff, analog_out_ff}, 17'h18300);
    i_host.scan(16'h0049, 16'h0000, 16'h0000);
    chk(cfg_new_clear_ff, 1'b1);
    tick();
    chk(analog_on_ff, 1'b0);
    axis_mode <= 2'h2;
    i_host.scan(16'h0024, 16'h3E80, 16'h0000);
    tick();
    chk(analog_on_ff, 1'b0);
    axis_mode <= 2'h0;
    pos_err <= 32'h5;
    enc_unref <= 1'b1;
    sp(32'h100, 8'h53);
    enc_unref <= 1'b0;
    moving <= 1'b1;
    sp(32'h100, 8'h61);
    moving <= 1'b0;
    prog_active <= 1'b1;
    sp(32'h100, 8'h61);
    prog_active <= 1'b0;
    in_zone <= 1'b0;
    act_vel_abs <= 32'h65;
    sp(32'h100, 8'h61);
    chk({pos_valid_ff, cmd_pos_ff}, 33'h0);
    act_vel_abs <= 32'h64;
    sp(32'h100, 8'h00);
    chk({pos_valid_ff, cmd_pos_ff, actual_pos_ff}, {1'b1, 32'h105, 32'h100});
    sp(32'h10001, 8'h63);
    i_host.rd(4'h5, rd_val);
    chk(rd_val, 16'h0063);
    i_host.rd(4'h9, rd_val);
    chk(rd_val, 16'h0000);
    aux_axis <= 1'b1;
    sp(32'h200, 8'h00);
    chk({cmd_pos_ff, actual_pos_ff}, {32'h200, 32'h100});
    aux_axis <= 1'b0;
    servo_on <= 1'b1;
    i_host.incr(8'h80);
    chk({incr_pulse_ff, incr_value_ff, cmd_pos_ff}, {1'b1, 8'h80, 32'h200});
    i_host.scan(16'h0022, 16'h0010, 16'h0000);
    i_host.null_scan();
    chk({vel_move_ff, vel_move_speed_ff}, 33'h100000010);
    pos_delta <= 16'h7FFF;
    tick();
    tick();
    pos_delta <= 16'h0000;
    chk(actual_pos_ff, 32'hFFFF00FD);
    rst_n <= 1'b0;
    tick();
    rst_n <= 1'b1;
    chk({rate_override_ff, vel_move_ff, pos_valid_ff, cmd_pos_ff}, {8'h64, 1'b0, 1'b0, 32'h0});
    wrap_up();
  end
endmodule // axis_immediate_command_decoder_tb_top
